// ==== logic/gpp_port.sv ====
// twenty-line general-purpose port with apb registers and startup window
`default_nettype none
module gpp_port #(
    parameter int STARTUP_CYCLES = gpp_pkg::STARTUP_CYCLES,
    parameter int CNT_W          = 22
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [19:0] pin_in,
    output logic [19:0]      pin_out,
    output logic [19:0]      pin_oe,
    input  wire logic [19:0] nv_pwrup_dir,
    input  wire logic [19:0] nv_pwrup_out,
    input  wire logic [5:0]  tc_out,
    input  wire logic [5:0]  tc_oe,
    output logic [5:0]       tc_in,
    input  wire logic        amux_en,
    input  wire logic [2:0]  amux_sel,
    output logic             startup_done
);
    localparam int NL = gpp_pkg::NUM_LINES;

    logic [19:0]      pin_meta_reg;
    logic [19:0]      pin_sync_reg;
    logic [19:0]      dir_reg;
    logic [19:0]      out_reg;
    logic [19:0]      pwrup_dir_reg;
    logic [19:0]      pwrup_out_reg;
    logic             nv_loaded_reg;
    logic [3:0]       tc_ofs_reg;
    logic [2:0]       tc_tmr_reg;
    logic [1:0]       tc_cnt_reg;
    logic [4:0]       line_sel_reg;
    logic [CNT_W-1:0] win_cnt_reg;
    gpp_pkg::gpp_state_t state_reg;

    // 23-bit software view: bits 20-22 mirror lines 16-18
    function automatic logic [22:0] view(input logic [19:0] x);
        view = {x[18:16], x};
    endfunction

    logic        setup;
    logic        access;
    logic        wr;
    logic        mapped;
    logic        tc_bad;
    logic        line_bad;
    logic        err_next;
    logic        win_end;
    logic [4:0]  line_phys;
    logic [3:0]  new_ofs;
    logic [2:0]  new_tmr;
    logic [1:0]  new_cnt;
    logic [3:0]  new_total;
    logic [1:0]  line_op;
    logic [2:0]  tc_total;

    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign wr       = access && pwrite && !pslverr;
    assign pready   = 1'b1; // zero wait: read data is captured in the setup cycle
    assign win_end  = (state_reg == gpp_pkg::GPP_ST_WINDOW)
                      && (win_cnt_reg == CNT_W'(STARTUP_CYCLES - 1));
    assign tc_total = tc_tmr_reg + {1'b0, tc_cnt_reg};

    // decode of pending write fields
    always_comb begin
        new_ofs   = pwdata[gpp_pkg::TC_OFS_LSB +: 4];
        new_tmr   = pwdata[gpp_pkg::TC_TMR_LSB +: 3];
        new_cnt   = pwdata[gpp_pkg::TC_CNT_LSB +: 2];
        new_total = {1'b0, new_tmr} + {2'b00, new_cnt};
        tc_bad    = (new_tmr > 3'(gpp_pkg::TC_MAX_TMR))
                    || (new_cnt > 2'(gpp_pkg::TC_MAX_CNT))
                    || (new_total > 4'(gpp_pkg::TC_MAX_LINES))
                    || (new_ofs > 4'(gpp_pkg::TC_OFS_MAX));
        line_op   = pwdata[gpp_pkg::LINE_OP_LSB +: 2];
        line_bad  = (pwdata[gpp_pkg::LINE_IDX_LSB +: 5] >= 5'(gpp_pkg::VIEW_W))
                    || (line_op == 2'h3);
        // indices 20-22 land on the same flops as 16-18
        if (pwdata[gpp_pkg::LINE_IDX_LSB +: 5] >= 5'(gpp_pkg::MUX_BASE)) begin
            line_phys = pwdata[gpp_pkg::LINE_IDX_LSB +: 5] - 5'h04;
        end else begin
            line_phys = pwdata[gpp_pkg::LINE_IDX_LSB +: 5];
        end
        case (paddr)
            gpp_pkg::ADDR_DIR, gpp_pkg::ADDR_OUT, gpp_pkg::ADDR_IN,
            gpp_pkg::ADDR_LINE, gpp_pkg::ADDR_PUDIR, gpp_pkg::ADDR_PUOUT,
            gpp_pkg::ADDR_TC, gpp_pkg::ADDR_STAT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        err_next = !mapped
                   || (pwrite && (paddr == gpp_pkg::ADDR_TC) && tc_bad)
                   || (pwrite && (paddr == gpp_pkg::ADDR_LINE) && line_bad);
    end

    // two-flop synchroniser on the pin levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= 20'h00000;
            pin_sync_reg <= 20'h00000;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // startup window state and counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= gpp_pkg::GPP_ST_WINDOW;
            win_cnt_reg <= '0;
        end else begin
            case (state_reg)
                gpp_pkg::GPP_ST_WINDOW: begin
                    win_cnt_reg <= win_cnt_reg + CNT_W'(1);
                    if (win_end) begin
                        state_reg <= gpp_pkg::GPP_ST_RUN;
                    end
                end
                gpp_pkg::GPP_ST_RUN: state_reg <= gpp_pkg::GPP_ST_RUN;
                default: state_reg <= gpp_pkg::GPP_ST_WINDOW;
            endcase
        end
    end
    assign startup_done = (state_reg == gpp_pkg::GPP_ST_RUN);

    // power-up configuration: factory zeros, then the stored copy, then software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwrup_dir_reg <= gpp_pkg::FACTORY_DIR;
            pwrup_out_reg <= gpp_pkg::FACTORY_OUT;
            nv_loaded_reg <= 1'b0;
        end else if (!nv_loaded_reg) begin
            pwrup_dir_reg <= nv_pwrup_dir;
            pwrup_out_reg <= nv_pwrup_out;
            nv_loaded_reg <= 1'b1;
        end else if (wr && paddr == gpp_pkg::ADDR_PUDIR) begin
            pwrup_dir_reg <= pwdata[19:0];
        end else if (wr && paddr == gpp_pkg::ADDR_PUOUT) begin
            pwrup_out_reg <= pwdata[19:0];
        end
    end

    // live direction and state; writes in the window are dropped since the
    // power-up image replaces everything at its end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_reg <= gpp_pkg::FACTORY_DIR;
            out_reg <= gpp_pkg::FACTORY_OUT;
        end else if (win_end) begin
            dir_reg <= pwrup_dir_reg;
            out_reg <= pwrup_out_reg;
        end else if (startup_done && wr) begin
            case (paddr)
                gpp_pkg::ADDR_DIR: dir_reg <= pwdata[19:0];
                gpp_pkg::ADDR_OUT: out_reg <= pwdata[19:0];
                gpp_pkg::ADDR_LINE: begin
                    // one line changes, all others keep their setting
                    dir_reg[line_phys] <= (line_op != gpp_pkg::OP_INPUT);
                    out_reg[line_phys] <= (line_op == gpp_pkg::OP_HIGH);
                end
                default: dir_reg <= dir_reg;
            endcase
        end
    end

    // timer/counter block and last-addressed line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_ofs_reg   <= 4'h0;
            tc_tmr_reg   <= 3'h0;
            tc_cnt_reg   <= 2'h0;
            line_sel_reg <= 5'h00;
        end else if (wr && paddr == gpp_pkg::ADDR_TC) begin
            tc_ofs_reg <= new_ofs;
            tc_tmr_reg <= new_tmr;
            tc_cnt_reg <= new_cnt;
        end else if (wr && paddr == gpp_pkg::ADDR_LINE) begin
            line_sel_reg <= line_phys;
        end
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= err_next;
            prdata  <= 32'h00000000;
            if (!pwrite) begin
                case (paddr)
                    gpp_pkg::ADDR_DIR:   prdata[22:0] <= view(dir_reg);
                    gpp_pkg::ADDR_OUT:   prdata[22:0] <= view(out_reg);
                    gpp_pkg::ADDR_IN:    prdata[22:0] <= view(pin_sync_reg);
                    gpp_pkg::ADDR_PUDIR: prdata[19:0] <= pwrup_dir_reg;
                    gpp_pkg::ADDR_PUOUT: prdata[19:0] <= pwrup_out_reg;
                    gpp_pkg::ADDR_TC: begin
                        prdata[gpp_pkg::TC_OFS_LSB +: 4] <= tc_ofs_reg;
                        prdata[gpp_pkg::TC_TMR_LSB +: 3] <= tc_tmr_reg;
                        prdata[gpp_pkg::TC_CNT_LSB +: 2] <= tc_cnt_reg;
                    end
                    gpp_pkg::ADDR_LINE: begin
                        prdata[gpp_pkg::LINE_IDX_LSB +: 5] <= line_sel_reg;
                        prdata[gpp_pkg::LINE_OP_LSB +: 2] <=
                            !dir_reg[line_sel_reg] ? gpp_pkg::OP_INPUT :
                            out_reg[line_sel_reg] ? gpp_pkg::OP_HIGH : gpp_pkg::OP_LOW;
                        prdata[gpp_pkg::LINE_PIN_BIT] <= pin_sync_reg[line_sel_reg];
                    end
                    gpp_pkg::ADDR_STAT:  prdata[0] <= startup_done;
                    default:             prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // per-line drive selection; block lines hand over to the timer/counter
    logic [19:0] oe_next;
    logic [19:0] out_next;
    logic [19:0] tc_own;
    logic [5:0]  tc_in_next;
    genvar gi;
    generate
        for (gi = 0; gi < NL; gi++) begin : g_line
            logic [4:0] rel;
            logic       own;
            // select index folded to zero off the mux lines so no select goes out of range
            localparam int SEL_IDX = (gi >= gpp_pkg::CTRL_BASE) ? (gi - gpp_pkg::CTRL_BASE) % 3 : 0;
            assign rel = 5'(gi) - {1'b0, tc_ofs_reg};
            if (gi < gpp_pkg::CTRL_BASE) begin : g_tc
                assign own = (5'(gi) >= {1'b0, tc_ofs_reg}) && (rel < {2'b00, tc_total});
            end else begin : g_notc
                assign own = 1'b0;
            end
            assign tc_own[gi] = own;
            always_comb begin
                if (!startup_done) begin
                    oe_next[gi]  = 1'b0;
                    out_next[gi] = 1'b0;
                end else if (own) begin
                    oe_next[gi]  = tc_oe[rel[2:0]];
                    out_next[gi] = tc_out[rel[2:0]];
                end else if (amux_en && gi >= gpp_pkg::CTRL_BASE
                             && gi < gpp_pkg::CTRL_BASE + gpp_pkg::MUX_LINES) begin
                    oe_next[gi]  = 1'b1;
                    out_next[gi] = amux_sel[SEL_IDX];
                end else begin
                    oe_next[gi]  = dir_reg[gi];
                    out_next[gi] = out_reg[gi];
                end
            end
        end
    endgenerate

    // route the block's sampled pins back to the timer/counter inputs
    always_comb begin
        tc_in_next = 6'h00;
        for (int k = 0; k < gpp_pkg::TC_MAX_LINES; k++) begin
            if (3'(k) < tc_total) begin
                tc_in_next[k] = pin_sync_reg[5'(k) + {1'b0, tc_ofs_reg}];
            end
        end
    end

    // registered pin drive: one cycle after a setting changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe  <= 20'h00000;
            pin_out <= 20'h00000;
            tc_in   <= 6'h00;
        end else begin
            pin_oe  <= oe_next;
            pin_out <= out_next;
            tc_in   <= tc_in_next;
        end
    end

    // checks
    sequence s_dir_wr;
        access && pwrite && !pslverr && paddr == gpp_pkg::ADDR_DIR && startup_done;
    endsequence
    sequence s_in_rd;
        setup && !pwrite && paddr == gpp_pkg::ADDR_IN;
    endsequence
    sequence s_alias_high;
        access && pwrite && !pslverr && startup_done && paddr == gpp_pkg::ADDR_LINE
        && pwdata[4:0] >= 5'h14 && line_op == gpp_pkg::OP_HIGH;
    endsequence

    AST_WINDOW_NO_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
        !startup_done |=> ##1 (pin_oe == 20'h00000 || startup_done))
        else $error("line driven inside startup window");
    AST_WINDOW_APPLY: assert property (@(posedge pclk) disable iff (!presetn)
        win_end |=> (dir_reg == $past(pwrup_dir_reg)) && (out_reg == $past(pwrup_out_reg)))
        else $error("power-up image not applied at window end");
    AST_DIR_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        s_dir_wr |=> dir_reg == $past(pwdata[19:0]))
        else $error("direction write not stored bit for bit");
    AST_ALIAS: assert property (@(posedge pclk) disable iff (!presetn)
        s_alias_high |=> dir_reg[$past(line_phys)] && out_reg[$past(line_phys)]
        && $past(line_phys) >= 5'h10 && $past(line_phys) <= 5'h12)
        else $error("mux index did not reach its control line");
    AST_PIN_READ: assert property (@(posedge pclk) disable iff (!presetn)
        s_in_rd |=> prdata[19:0] == $past(pin_sync_reg)
        && prdata[22:20] == $past(pin_sync_reg[18:16]))
        else $error("input read does not match sampled pins");
    AST_TC_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
        tc_tmr_reg <= 3'h4 && tc_cnt_reg <= 2'h2 && tc_total <= 3'h6 && tc_ofs_reg <= 4'h8)
        else $error("timer/counter block outside its limits");
    AST_TC_OWNS: assert property (@(posedge pclk) disable iff (!presetn)
        startup_done && tc_total != 3'h0 |=>
        pin_oe[$past(tc_ofs_reg)] == $past(tc_oe[0])
        && pin_out[$past(tc_ofs_reg)] == $past(tc_out[0]))
        else $error("block line not driven by its function");
    AST_GPIO_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
        startup_done && !tc_own[8] |=> pin_oe[8] == $past(dir_reg[8])
        && pin_out[8] == $past(out_reg[8]))
        else $error("line drive does not follow direction and state");
    AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !mapped |=> pslverr)
        else $error("unmapped access not flagged");
endmodule
`default_nettype wire

// ==== logic/gpp_pkg.sv ====
// constants, register map and types of the general-purpose line port
`default_nettype none
package gpp_pkg;
    // line numbering in the 23-bit software view
    localparam int NUM_LINES     = 20;
    localparam int VIEW_W        = 23;
    localparam int FLEX_BASE     = 0;
    localparam int EXT_BASE      = 8;
    localparam int CTRL_BASE     = 16;
    localparam int MUX_BASE      = 20;
    localparam int MUX_LINES     = 3;
    // register byte offsets
    localparam logic [7:0] ADDR_DIR   = 8'h00;
    localparam logic [7:0] ADDR_OUT   = 8'h04;
    localparam logic [7:0] ADDR_IN    = 8'h08;
    localparam logic [7:0] ADDR_LINE  = 8'h0C;
    localparam logic [7:0] ADDR_PUDIR = 8'h10;
    localparam logic [7:0] ADDR_PUOUT = 8'h14;
    localparam logic [7:0] ADDR_TC    = 8'h18;
    localparam logic [7:0] ADDR_STAT  = 8'h1C;
    // single-line command fields and codes
    localparam int LINE_IDX_LSB  = 0;
    localparam int LINE_OP_LSB   = 8;
    localparam int LINE_PIN_BIT  = 12;
    localparam logic [1:0] OP_INPUT = 2'h0;
    localparam logic [1:0] OP_HIGH  = 2'h1;
    localparam logic [1:0] OP_LOW   = 2'h2;
    // timer/counter block fields and limits
    localparam int TC_OFS_LSB    = 0;
    localparam int TC_TMR_LSB    = 4;
    localparam int TC_CNT_LSB    = 8;
    localparam int TC_MAX_LINES  = 6;
    localparam int TC_MAX_TMR    = 4;
    localparam int TC_MAX_CNT    = 2;
    localparam int TC_OFS_MAX    = 8;
    // values after reset: factory state is all inputs
    localparam logic [19:0] FACTORY_DIR = 20'h00000;
    localparam logic [19:0] FACTORY_OUT = 20'h00000;
    // startup window
    localparam int STARTUP_MS     = 100;
    localparam int CLK_HZ         = 40_000_000;
    localparam int STARTUP_CYCLES = STARTUP_MS * (CLK_HZ / 1000);
    typedef enum logic [1:0] {
        GPP_ST_WINDOW = 2'b01,
        GPP_ST_RUN    = 2'b10
    } gpp_state_t;
endpackage
`default_nettype wire

// ==== test/gpp_pins_model.sv ====
// connector-side model: pull-ups on released lines plus optional outside drivers
`default_nettype none
module gpp_pins_model (
    input  wire logic [19:0] pin_out,
    input  wire logic [19:0] pin_oe,
    input  wire logic [19:0] ext_en,
    input  wire logic [19:0] ext_val,
    output logic [19:0]      pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // a driving port wins over an outside source; a released line floats up to the pull-up
    always_comb begin
        for (int i = 0; i < 20; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule
`default_nettype wire

// ==== test/gpp_port_bench.sv ====
// self-checking bench for the general-purpose line port
`default_nettype none
module gpp_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SU = 50;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        amux_en, startup_done;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [19:0] pin_in, pin_out, pin_oe, nv_dir, nv_out, ext_en, ext_val, dir_m, out_m, lv;
    logic [5:0]  tc_out, tc_oe, tc_in;
    logic [2:0]  amux_sel;
    logic [1:0]  op;
    int          failures = 0, num_checks = 0, cyc = 0, tc_ofs, tc_n, x;

    gpp_port #(.STARTUP_CYCLES(SU)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .nv_pwrup_dir(nv_dir), .nv_pwrup_out(nv_out), .tc_out(tc_out),
        .tc_oe(tc_oe), .tc_in(tc_in), .amux_en(amux_en), .amux_sel(amux_sel),
        .startup_done(startup_done));
    gpp_pins_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    // 40 MHz bench clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // hang guard: the whole sequence needs well under this many cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    task report_and_stop();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; request held until pready is seen high at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // expected pin levels from the bench's own view of the configuration
    function automatic logic [19:0] exp_lvl();
        logic [19:0] v;
        int          k;
        for (int i = 0; i < 20; i++) begin
            k = i - tc_ofs;
            if (k >= 0 && k < tc_n) v[i] = tc_oe[k] ? tc_out[k] : (ext_en[i] ? ext_val[i] : 1'b1);
            else if (amux_en && i >= 16 && i <= 18) v[i] = amux_sel[i-16];
            else if (dir_m[i]) v[i] = out_m[i];
            else v[i] = ext_en[i] ? ext_val[i] : 1'b1;
        end
        return v;
    endfunction

    // expected timer/counter inputs: slot k sees the level of line offset+k
    function automatic logic [5:0] exp_tc();
        logic [5:0] t;
        t = 6'h00;
        for (int k = 0; k < 6; k++) begin
            if (k < tc_n) t[k] = lv[tc_ofs + k];
        end
        return t;
    endfunction

    // drive change and the two sync stages settle within the five edges before the registered read
    task read_lines(input string nm);
        repeat (5) @(posedge pclk);
        apb(1'b0, gpp_pkg::ADDR_IN, 32'h00000000);
        lv = exp_lvl();
        chk(nm, {12'h000, lv}, {12'h000, rd[19:0]});
    endtask

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h00000000; tc_out = 6'h00; tc_oe = 6'h00; amux_en = 1'b0;
        amux_sel = 3'h0; nv_dir = 20'h000A5; nv_out = 20'h00021; ext_en = 20'h00000;
        ext_val = 20'h00000; dir_m = 20'h00000; out_m = 20'h00000; tc_ofs = 0; tc_n = 0;
        rd = $urandom(89);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // writes inside the startup window must not reach the pins
        apb(1'b1, gpp_pkg::ADDR_DIR, 32'h000FFFFF);
        chk("pin_oe in window", 32'h0, {12'h000, pin_oe});
        chk("startup_done in window", 32'h0, {31'h0, startup_done});
        apb(1'b0, gpp_pkg::ADDR_PUDIR, 32'h00000000);
        chk("pwrup dir", {12'h000, nv_dir}, rd);
        for (int i = 0; i < 100 && startup_done !== 1'b1; i++) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk("pin_oe after window", {12'h000, nv_dir}, {12'h000, pin_oe});
        chk("startup_done", 32'h1, {31'h0, startup_done});
        apb(1'b0, gpp_pkg::ADDR_STAT, 32'h00000000);
        chk("stat", 32'h1, rd);
        dir_m = nv_dir;
        out_m = nv_out;
        read_lines("pwrup levels");
        // bulk random direction and state
        repeat (6) begin
            dir_m = 20'($urandom);
            out_m = 20'($urandom);
            ext_en <= 20'($urandom);
            ext_val <= 20'($urandom);
            apb(1'b1, gpp_pkg::ADDR_DIR, {12'h000, dir_m});
            apb(1'b1, gpp_pkg::ADDR_OUT, {12'h000, out_m});
            repeat (2) @(posedge pclk);
            chk("pin_oe", {12'h000, dir_m}, {12'h000, pin_oe});
            read_lines("bulk levels");
            apb(1'b0, gpp_pkg::ADDR_DIR, 32'h00000000);
            chk("dir mirror", {9'h000, dir_m[18:16], dir_m}, rd);
        end
        // every index, ops cycling; 20-22 land on lines 16-18
        for (int i = 0; i < 23; i++) begin
            case (i % 3)
                0: op = gpp_pkg::OP_INPUT;
                1: op = gpp_pkg::OP_HIGH;
                default: op = gpp_pkg::OP_LOW;
            endcase
            x = (i < 20) ? i : i - 4;
            apb(1'b1, gpp_pkg::ADDR_LINE, {22'h000000, op, 3'h0, 5'(i)});
            chk("line err", 32'h0, {31'h0, err});
            dir_m[x] = (op != gpp_pkg::OP_INPUT);
            out_m[x] = (op == gpp_pkg::OP_HIGH);
            read_lines("line levels");
        end
        apb(1'b1, gpp_pkg::ADDR_LINE, 32'h00000301);
        chk("bad op err", 32'h1, {31'h0, err});
        apb(1'b0, 8'h20, 32'h00000000);
        chk("unmapped err", 32'h1, {31'h0, err});
        // last good line command was index 22, driven high, landing on line 18
        apb(1'b0, gpp_pkg::ADDR_LINE, 32'h00000000);
        chk("line readback", {19'h00000, lv[18], 2'h0, gpp_pkg::OP_HIGH, 3'h0, 5'h12}, rd);
        // timer/counter block: small, widest at the last offset, then an illegal timer number
        tc_oe <= 6'($urandom);
        tc_out <= 6'($urandom);
        apb(1'b1, gpp_pkg::ADDR_TC, {22'h000000, 2'h1, 1'b0, 3'h2, 4'h2});
        tc_ofs = 2;
        tc_n = 3;
        read_lines("tc block");
        chk("tc_in block", {26'h0, exp_tc()}, {26'h0, tc_in});
        apb(1'b1, gpp_pkg::ADDR_TC, {22'h000000, 2'h2, 1'b0, 3'h4, 4'h8});
        chk("tc max err", 32'h0, {31'h0, err});
        tc_ofs = 8;
        tc_n = 6;
        read_lines("tc wide");
        chk("tc_in wide", {26'h0, exp_tc()}, {26'h0, tc_in});
        apb(1'b1, gpp_pkg::ADDR_TC, {22'h000000, 2'h0, 1'b0, 3'h5, 4'h0});
        chk("tc over err", 32'h1, {31'h0, err});
        read_lines("tc kept");
        apb(1'b0, gpp_pkg::ADDR_TC, 32'h00000000);
        chk("tc readback", {22'h000000, 2'h2, 1'b0, 3'h4, 4'h8}, rd);
        apb(1'b1, gpp_pkg::ADDR_TC, 32'h00000000);
        tc_ofs = 0;
        tc_n = 0;
        // analog mux selects take lines 16-18
        amux_en <= 1'b1;
        amux_sel <= 3'h5;
        read_lines("amux lines");
        // software power-up direction: all eight flexible lines as outputs
        apb(1'b1, gpp_pkg::ADDR_PUDIR, 32'h000000FF);
        apb(1'b0, gpp_pkg::ADDR_PUDIR, 32'h00000000);
        chk("pwrup dir write", 32'h000000FF, rd);
        report_and_stop();
    end
endmodule
`default_nettype wire
